/* brmd_pkg.sv */
package brmd_pkg;

  // matrix shape
  localparam int NUM_MST = 11;
  localparam int NUM_SLV = 8;
  localparam int NUM_LAYERS = 12;
  localparam int MST_W = 4;
  localparam int SLV_W = 3;

  // master numbers
  localparam int MST_CPU_I = 0;
  localparam int MST_CPU_D = 1;
  localparam int MST_PERIPH_DMA = 2;
  localparam int MST_LCD = 7;
  localparam int MST_ETH = 8;

  // slave numbers
  localparam logic [2:0] SLV_SRAM = 3'h0;
  localparam logic [2:0] SLV_ROM = 3'h1;
  localparam logic [2:0] SLV_DDR0 = 3'h2;
  localparam logic [2:0] SLV_DDR1 = 3'h3;
  localparam logic [2:0] SLV_DDR2 = 3'h4;
  localparam logic [2:0] SLV_DDR3 = 3'h5;
  localparam logic [2:0] SLV_EBI = 3'h6;
  localparam logic [2:0] SLV_PERIPH = 3'h7;

  // wired paths, one bit per slave
  localparam logic [7:0] PATH_ALL = 8'hff;
  localparam logic [7:0] PATH_ETH = 8'h7f;

  // address map, megabyte numbers and bases
  localparam logic [11:0] MB_BOOT = 12'h000;
  localparam logic [11:0] MB_SRAM_A = 12'h001;
  localparam logic [11:0] MB_SRAM_B = 12'h002;
  localparam logic [11:0] MB_SRAM_C = 12'h003;
  localparam logic [11:0] MB_ROM = 12'h004;
  localparam logic [11:0] MB_INT_LO = 12'h005;
  localparam logic [11:0] MB_INT_HI = 12'h00f;
  localparam logic [31:0] SRAM_C_BASE = 32'h0030_0000;
  localparam logic [31:0] ROM_BASE = 32'h0040_0000;
  localparam logic [31:0] EBI_CS0_BASE = 32'h1000_0000;
  localparam logic [3:0] EBI_NIB_LO = 4'h1;
  localparam logic [3:0] EBI_NIB_HI = 4'h6;
  localparam logic [3:0] DDR_NIB = 4'h7;
  localparam logic [31:0] PERIPH_LO = 32'hfff7_8000;
  localparam logic [31:0] PERIPH_HI = 32'hfffc_ffff;

  // sram split
  localparam logic [19:0] SIZE_0K = 20'h00000;
  localparam logic [19:0] SIZE_32K = 20'h08000;
  localparam logic [19:0] SIZE_64K = 20'h10000;
  localparam logic [1:0] LAYOUT_C64 = 2'h0;
  localparam logic [1:0] LAYOUT_B64 = 2'h1;
  localparam logic [1:0] LAYOUT_AB32 = 2'h2;

  // arbiter modes
  localparam logic [1:0] ARB_FIXED = 2'h0;
  localparam logic [1:0] ARB_RR_NODEF = 2'h1;
  localparam logic [1:0] ARB_RR_LAST = 2'h2;
  localparam logic [1:0] ARB_RR_FIXDEF = 2'h3;

  // register map (byte addresses) and fields
  localparam logic [7:0] REG_REMAP = 8'h00;
  localparam logic [7:0] REG_SRAM_CFG = 8'h04;
  localparam logic [7:0] REG_DDR_CFG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [2:0] REG_ARB_BLK = 3'h2;
  localparam int ARB_MODE_LSB = 0;
  localparam int ARB_DEF_LSB = 4;
  localparam int ARB_SLOT_LSB = 8;

  // reset values
  localparam logic [15:0] ARB_CFG_RST = 16'h1002;
  localparam logic [1:0] LAYOUT_RST = 2'h0;
  localparam logic DDRDIS_RST = 1'b0;

endpackage

/* brmd_matrix.sv */
// Functional notes
// - boot memory answers at address zero
// - first megabyte reserved for boot mapping
// - boot select high routes boot region ROM
// - boot select low routes to chip select zero
// - ROM always at its fixed base
// - with boot select high, ROM also at zero, for all masters until remap, non-CPU masters after
// - general SRAM only at base before remap
// - after remap SRAM C at zero in layout LAYOUT_C64, CPU only
// - every block at its own base, but SRAM A, B and C only in the layouts that give them a nonzero size
// - software SRAM split, three layouts
// - multiport: CPU to DDR0/DDR1, rest shared
// - multiport off: DDR1 for display master
// - twelve layers, eleven masters
// - one decoder per master, varied by master number and wired paths
// - one independently programmed arbiter per slave
// - fixed priority or round robin, default kinds
// - slot limit breaks bursts, open-length bursts
// - masters reach different slaves concurrently
// - unwired paths cannot reach the slave
`timescale 1ns/1ps
`default_nettype none

module brmd_decoder #(
  parameter int         MST_ID    = 0,
  parameter logic [7:0] PATH_MASK = 8'hff
) (
  input  wire logic [31:0] addr,
  input  wire logic        remap,
  input  wire logic        bootSel,
  input  wire logic [1:0]  layout,
  input  wire logic        ddrDis,
  output logic             hit,
  output logic [2:0]       slave,
  output logic [31:0]      outAddr
);
  localparam bit IS_CPU = (MST_ID == brmd_pkg::MST_CPU_I) || (MST_ID == brmd_pkg::MST_CPU_D);

  logic [19:0] sizeA;
  logic [19:0] sizeB;
  logic [19:0] sizeC;
  logic [11:0] mb;
  logic [19:0] offs;
  logic [2:0]  ddrPort;
  logic        rawHit;

  assign mb = addr[31:20];
  assign offs = addr[19:0];

  always_comb begin
    case (layout)
      brmd_pkg::LAYOUT_B64: begin
        sizeA = brmd_pkg::SIZE_0K;
        sizeB = brmd_pkg::SIZE_64K;
        sizeC = brmd_pkg::SIZE_0K;
      end
      brmd_pkg::LAYOUT_AB32: begin
        sizeA = brmd_pkg::SIZE_32K;
        sizeB = brmd_pkg::SIZE_32K;
        sizeC = brmd_pkg::SIZE_0K;
      end
      default: begin
        sizeA = brmd_pkg::SIZE_0K;
        sizeB = brmd_pkg::SIZE_0K;
        sizeC = brmd_pkg::SIZE_64K;
      end
    endcase
  end

  always_comb begin
    if (!ddrDis && MST_ID == brmd_pkg::MST_CPU_I) begin
      ddrPort = brmd_pkg::SLV_DDR0;
    end else if (!ddrDis && MST_ID == brmd_pkg::MST_CPU_D) begin
      ddrPort = brmd_pkg::SLV_DDR1;
    end else if (ddrDis && MST_ID == brmd_pkg::MST_LCD) begin
      ddrPort = brmd_pkg::SLV_DDR1;
    end else if ((MST_ID % 2) == 1) begin
      ddrPort = brmd_pkg::SLV_DDR3;
    end else begin
      ddrPort = brmd_pkg::SLV_DDR2;
    end
  end

  always_comb begin
    rawHit = 1'b0;
    slave = brmd_pkg::SLV_SRAM;
    outAddr = addr;
    if (mb == brmd_pkg::MB_BOOT) begin
      if (remap && IS_CPU) begin
        rawHit = offs < sizeC;
        slave = brmd_pkg::SLV_SRAM;
        outAddr = brmd_pkg::SRAM_C_BASE | {12'h000, offs};
      end else if (bootSel) begin
        rawHit = 1'b1;
        slave = brmd_pkg::SLV_ROM;
        outAddr = brmd_pkg::ROM_BASE | {12'h000, offs};
      end else begin
        rawHit = 1'b1;
        slave = brmd_pkg::SLV_EBI;
        outAddr = brmd_pkg::EBI_CS0_BASE | {12'h000, offs};
      end
    end else if (mb == brmd_pkg::MB_SRAM_A) begin
      rawHit = offs < sizeA;
    end else if (mb == brmd_pkg::MB_SRAM_B) begin
      rawHit = offs < sizeB;
    end else if (mb == brmd_pkg::MB_SRAM_C) begin
      rawHit = offs < sizeC;
    end else if (mb == brmd_pkg::MB_ROM) begin
      rawHit = 1'b1;
      slave = brmd_pkg::SLV_ROM;
    end else if (mb >= brmd_pkg::MB_INT_LO && mb <= brmd_pkg::MB_INT_HI) begin
      rawHit = 1'b1;
      slave = brmd_pkg::SLV_ROM;
    end else if (addr[31:28] >= brmd_pkg::EBI_NIB_LO && addr[31:28] <= brmd_pkg::EBI_NIB_HI) begin
      rawHit = 1'b1;
      slave = brmd_pkg::SLV_EBI;
    end else if (addr[31:28] == brmd_pkg::DDR_NIB) begin
      rawHit = 1'b1;
      slave = ddrPort;
    end else if (addr >= brmd_pkg::PERIPH_LO && addr <= brmd_pkg::PERIPH_HI) begin
      rawHit = 1'b1;
      slave = brmd_pkg::SLV_PERIPH;
    end
    hit = rawHit && PATH_MASK[slave];
  end
endmodule

module brmd_arbiter #(
  parameter int NM = 11,
  parameter int MW = 4
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [NM-1:0] reqVec,
  input  wire logic [1:0]    mode,
  input  wire logic [MW-1:0] defMaster,
  input  wire logic [7:0]    slotLimit,
  output logic               nxtActive,
  output logic [MW-1:0]      nxtOwner
);
  logic [MW-1:0] owner_ff;
  logic          active_ff;
  logic [7:0]    slotCnt_ff;
  logic [NM-1:0] others;
  logic [NM-1:0] cand;
  logic          brk;
  logic          keep;
  logic [MW-1:0] fxWin;
  logic [MW-1:0] rrWin;
  logic          rrFound;
  int            idx;

  always_comb begin
    idx = 0;
    others = reqVec & ~(NM'(1) << owner_ff);
    brk = active_ff && (slotLimit != 8'h00) && (slotCnt_ff >= slotLimit) && (|others);
    keep = active_ff && reqVec[owner_ff] && !brk;
    cand = brk ? others : reqVec;
    fxWin = owner_ff;
    for (int i = NM - 1; i >= 0; i--) begin
      if (cand[i]) begin
        fxWin = MW'(i);
      end
    end
    rrWin = owner_ff;
    rrFound = 1'b0;
    for (int k = 1; k <= NM; k++) begin
      idx = int'(owner_ff) + k;
      if (idx >= NM) begin
        idx = idx - NM;
      end
      if (cand[idx] && !rrFound) begin
        rrWin = MW'(idx);
        rrFound = 1'b1;
      end
    end
    if (keep) begin
      nxtActive = 1'b1;
      nxtOwner = owner_ff;
    end else if (|cand) begin
      nxtActive = 1'b1;
      nxtOwner = (mode == brmd_pkg::ARB_FIXED) ? fxWin : rrWin;
    end else begin
      nxtActive = 1'b0;
      nxtOwner = (mode == brmd_pkg::ARB_RR_FIXDEF) ? defMaster : owner_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      owner_ff <= '0;
      active_ff <= 1'b0;
    end else begin
      owner_ff <= nxtOwner;
      active_ff <= nxtActive;
    end
  end

  // slot count of the current tenure, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slotCnt_ff <= 8'h00;
    end else if (nxtActive && active_ff && nxtOwner == owner_ff) begin
      slotCnt_ff <= (slotCnt_ff == 8'hff) ? slotCnt_ff : slotCnt_ff + 8'h01;
    end else begin
      slotCnt_ff <= 8'h00;
    end
  end
endmodule

module brmd_matrix (
  input  wire logic                                              clk,
  input  wire logic                                              rst_n,
  input  wire logic                                              bootSelectLevel,
  input  wire logic [7:0]                                        regAddr,
  input  wire logic [31:0]                                       regWrData,
  input  wire logic                                              regWr,
  input  wire logic                                              regRd,
  output logic      [31:0]                                       regRdData,
  input  wire logic [brmd_pkg::NUM_MST-1:0]                      mstReq,
  input  wire logic [brmd_pkg::NUM_MST-1:0][31:0]                mstAddr,
  output logic      [brmd_pkg::NUM_MST-1:0]                      mstGnt,
  output logic      [brmd_pkg::NUM_MST-1:0]                      mstErr,
  output logic      [brmd_pkg::NUM_SLV-1:0]                      slvValid,
  output logic      [brmd_pkg::NUM_SLV-1:0][brmd_pkg::MST_W-1:0] slvOwner,
  output logic      [brmd_pkg::NUM_SLV-1:0][31:0]                slvAddr
);
  localparam int NM = brmd_pkg::NUM_MST;
  localparam int NS = brmd_pkg::NUM_SLV;
  localparam int MW = brmd_pkg::MST_W;

  logic                   bootSel_ff;
  logic                   bootCaught_ff;
  logic                   remap_ff;
  logic [1:0]             layout_ff;
  logic                   ddrDis_ff;
  logic [NS-1:0][15:0]    arbCfg_ff;
  logic [NM-1:0]          decHit;
  logic [NM-1:0][2:0]     decSlave;
  logic [NM-1:0][31:0]    decAddr;
  logic [NS-1:0][NM-1:0]  slvReq;
  logic [NS-1:0]          arbActive;
  logic [NS-1:0][MW-1:0]  arbOwner;
  logic [NM-1:0]          nxt_mstGnt;
  logic [31:0]            nxt_regRdData;
  logic [2:0]             arbSel;
  logic                   arbHit;

  assign arbSel = regAddr[4:2];
  assign arbHit = (regAddr[7:5] == brmd_pkg::REG_ARB_BLK) && (regAddr[1:0] == 2'h0);

  // boot select is caught in the first cycle after reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bootSel_ff <= 1'b0;
      bootCaught_ff <= 1'b0;
    end else if (!bootCaught_ff) begin
      bootSel_ff <= bootSelectLevel;
      bootCaught_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remap_ff <= 1'b0;
    end else if (regWr && regAddr == brmd_pkg::REG_REMAP && regWrData[0]) begin
      remap_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      layout_ff <= brmd_pkg::LAYOUT_RST;
    end else if (regWr && regAddr == brmd_pkg::REG_SRAM_CFG && regWrData[1:0] != 2'h3) begin
      layout_ff <= regWrData[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ddrDis_ff <= brmd_pkg::DDRDIS_RST;
    end else if (regWr && regAddr == brmd_pkg::REG_DDR_CFG) begin
      ddrDis_ff <= regWrData[0];
    end
  end

  // per-slave arbiter settings; out-of-range default masters are not taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < NS; s++) begin
        arbCfg_ff[s] <= brmd_pkg::ARB_CFG_RST;
      end
    end else if (regWr && arbHit) begin
      arbCfg_ff[arbSel][brmd_pkg::ARB_MODE_LSB +: 2] <= regWrData[brmd_pkg::ARB_MODE_LSB +: 2];
      arbCfg_ff[arbSel][brmd_pkg::ARB_SLOT_LSB +: 8] <= regWrData[brmd_pkg::ARB_SLOT_LSB +: 8];
      if (regWrData[brmd_pkg::ARB_DEF_LSB +: MW] < MW'(NM)) begin
        arbCfg_ff[arbSel][brmd_pkg::ARB_DEF_LSB +: MW] <= regWrData[brmd_pkg::ARB_DEF_LSB +: MW];
      end
    end
  end

  always_comb begin
    nxt_regRdData = 32'h0000_0000;
    if (arbHit) begin
      nxt_regRdData = {16'h0000, arbCfg_ff[arbSel]};
    end else begin
      case (regAddr)
        brmd_pkg::REG_REMAP: nxt_regRdData = {31'h0, remap_ff};
        brmd_pkg::REG_SRAM_CFG: nxt_regRdData = {30'h0, layout_ff};
        brmd_pkg::REG_DDR_CFG: nxt_regRdData = {31'h0, ddrDis_ff};
        brmd_pkg::REG_STATUS: nxt_regRdData = {29'h0, bootCaught_ff, remap_ff, bootSel_ff};
        default: nxt_regRdData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= regRd ? nxt_regRdData : 32'h0000_0000;
    end
  end

  // one decoder per master, differing in master number (boot remap, ddr port) and wired paths
  for (genvar m = 0; m < NM; m++) begin : gDec
    brmd_decoder #(
      .MST_ID    (m),
      .PATH_MASK ((m == brmd_pkg::MST_ETH) ? brmd_pkg::PATH_ETH : brmd_pkg::PATH_ALL)
    ) uDec (
      .addr    (mstAddr[m]),
      .remap   (remap_ff),
      .bootSel (bootSel_ff),
      .layout  (layout_ff),
      .ddrDis  (ddrDis_ff),
      .hit     (decHit[m]),
      .slave   (decSlave[m]),
      .outAddr (decAddr[m])
    );
  end

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      for (int m = 0; m < NM; m++) begin
        slvReq[s][m] = mstReq[m] && decHit[m] && (decSlave[m] == 3'(s));
      end
    end
  end

  for (genvar s = 0; s < NS; s++) begin : gArb
    brmd_arbiter #(
      .NM (NM),
      .MW (MW)
    ) uArb (
      .clk       (clk),
      .rst_n     (rst_n),
      .reqVec    (slvReq[s]),
      .mode      (arbCfg_ff[s][brmd_pkg::ARB_MODE_LSB +: 2]),
      .defMaster (arbCfg_ff[s][brmd_pkg::ARB_DEF_LSB +: MW]),
      .slotLimit (arbCfg_ff[s][brmd_pkg::ARB_SLOT_LSB +: 8]),
      .nxtActive (arbActive[s]),
      .nxtOwner  (arbOwner[s])
    );
  end

  always_comb begin
    nxt_mstGnt = '0;
    for (int s = 0; s < NS; s++) begin
      for (int m = 0; m < NM; m++) begin
        if (arbActive[s] && arbOwner[s] == MW'(m)) begin
          nxt_mstGnt[m] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mstGnt <= '0;
      mstErr <= '0;
    end else begin
      mstGnt <= nxt_mstGnt;
      mstErr <= mstReq & ~decHit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slvValid <= '0;
      slvOwner <= '0;
      slvAddr <= '0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        slvValid[s] <= arbActive[s];
        slvOwner[s] <= arbOwner[s];
        slvAddr[s] <= decAddr[arbOwner[s]];
      end
    end
  end
endmodule

`default_nettype wire

/* brmd_matrix_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module brmd_matrix_checker (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              regRd,
  input wire logic [31:0]       regRdData,
  input wire logic [10:0]       mstReq,
  input wire logic [10:0][31:0] mstAddr,
  input wire logic [10:0]       mstGnt,
  input wire logic [10:0]       mstErr,
  input wire logic [7:0]        slvValid,
  input wire logic [7:0][3:0]   slvOwner,
  input wire logic [7:0][31:0]  slvAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data not zero outside its slot");
  chk_rom_range: assert property (slvValid[1] |-> slvAddr[1][31:20] inside {[12'h004:12'h00f]})
    else $error("rom slave given an untranslated address");
  chk_ebi_range: assert property (slvValid[6] |-> slvAddr[6][31:28] inside {[4'h1:4'h6]})
    else $error("bus interface slave address out of range");
  chk_sram_range: assert property (slvValid[0] |-> slvAddr[0][31:16] inside {16'h0010, 16'h0020, 16'h0030})
    else $error("sram slave address out of range");
  chk_ddr0_cpu: assert property (slvValid[2] |-> slvOwner[2] == 4'h0)
    else $error("ddr port 0 owned by a non instruction master");
  chk_ddr_addr: assert property (slvValid[4] |-> slvAddr[4][31:28] == 4'h7)
    else $error("ddr port 2 address outside ddr");
  chk_ddr1_owner: assert property (slvValid[3] |-> slvOwner[3] == 4'h1 || slvOwner[3] == 4'h7)
    else $error("ddr port 1 owned by a wrong master");
  chk_eth_path: assert property (slvValid[7] |-> slvOwner[7] != 4'h8)
    else $error("network master reached peripherals");
  chk_eth_err: assert property (mstReq[8] && mstAddr[8] >= 32'hfff7_8000 && mstAddr[8] <= 32'hfffc_ffff
    |=> mstErr[8])
    else $error("unwired path gave no error");
  chk_gnt_req: assert property ((mstGnt & ~$past(mstReq)) == 11'h0)
    else $error("grant without request");
  chk_err_req: assert property ((mstErr & ~$past(mstReq)) == 11'h0)
    else $error("error without request");
endmodule
bind brmd_matrix brmd_matrix_checker brmd_matrix_checker_i (.clk(clk), .rst_n(rst_n), .regRd(regRd),
  .regRdData(regRdData), .mstReq(mstReq), .mstAddr(mstAddr), .mstGnt(mstGnt), .mstErr(mstErr),
  .slvValid(slvValid), .slvOwner(slvOwner), .slvAddr(slvAddr));
`default_nettype wire

/* brmd_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module brmd_master_model (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [10:0]       go,
  input  wire logic [10:0][31:0] goAddr,
  input  wire logic [10:0]       mstGnt,
  input  wire logic [10:0]       mstErr,
  output wire logic [10:0]       mstReq,
  output wire logic [10:0][31:0] mstAddr
);
  for (genvar m = 0; m < 11; m++) begin : g_mst
    logic        req_ff;
    logic [31:0] addr_ff;
    assign mstReq[m] = req_ff;
    assign mstAddr[m] = addr_ff;
    // request held until grant or error; idle address toggles so stale values never match
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        req_ff <= 1'b0;
        addr_ff <= 32'h0;
      end else if (go[m]) begin
        req_ff <= 1'b1;
        addr_ff <= goAddr[m];
      end else if (!req_ff || mstGnt[m] || mstErr[m]) begin
        req_ff <= 1'b0;
        addr_ff <= ~addr_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* brmd_matrix_test.sv */
`timescale 1ns/1ps
`default_nettype none
module brmd_matrix_test;
  typedef struct {logic rd; logic e; logic [3:0] m; logic [2:0] s; logic [31:0] v;} brmd_note_type;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              bootSelectLevel = 1'b1;
  logic [7:0]        regAddr = 8'h00;
  logic [31:0]       regWrData = 32'h0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [31:0]       regRdData;
  logic [10:0]       mstReq, mstGnt, mstErr;
  logic [10:0]       go = '0, prevGnt = '0, prevErr = '0;
  logic [10:0][31:0] mstAddr;
  logic [10:0][31:0] goAddr = '0;
  logic [7:0]        slvValid;
  logic [7:0][3:0]   slvOwner;
  logic [7:0][31:0]  slvAddr;
  logic [15:0]       seed = 16'hf4bb;
  logic              rdFlag = 1'b0;
  int                failures = 0;
  int                tests_run = 0;
  int                cycles = 0;
  brmd_note_type     notes[$];
  always #25 clk = ~clk;

  brmd_matrix brmd_matrix_i (.clk(clk), .rst_n(rst_n), .bootSelectLevel(bootSelectLevel), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .mstReq(mstReq),
    .mstAddr(mstAddr), .mstGnt(mstGnt), .mstErr(mstErr), .slvValid(slvValid), .slvOwner(slvOwner),
    .slvAddr(slvAddr));
  brmd_master_model brmd_master_model_i (.clk(clk), .rst_n(rst_n), .go(go), .goAddr(goAddr),
    .mstGnt(mstGnt), .mstErr(mstErr), .mstReq(mstReq), .mstAddr(mstAddr));

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // oldest note is matched against each result as it appears
  task automatic pop(input logic rd, input logic [3:0] m);
    brmd_note_type t;
    if (notes.size() == 0) check(40'h1, 40'h0);
    else begin
      t = notes.pop_front();
      if (t.rd !== rd) check(40'h1, 40'h0);
      else if (rd) check({8'h0, regRdData}, {8'h0, t.v});
      else if (t.e) check({t.m, 35'h0, mstErr[m]}, {m, 36'h1});
      else check({3'h0, slvValid[t.s], slvOwner[t.s], slvAddr[t.s]}, {3'h0, 1'b1, m, t.v});
    end
  endtask

  always @(negedge clk) begin
    if (rdFlag) pop(1'b1, 4'h0);
    rdFlag = regRd;
    for (int m = 0; m < 11; m++) begin
      if (mstGnt[m] && !prevGnt[m]) pop(1'b0, 4'(m));
      if (mstErr[m] && !prevErr[m]) pop(1'b0, 4'(m));
    end
    prevGnt = mstGnt;
    prevErr = mstErr;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  function automatic logic [31:0] rnd(input logic [31:0] mask);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {16'h0, seed} & mask & 32'hffff_fffc;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{1'b1, 1'b0, 4'h0, 3'h0, e});
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic launch(input int m, input logic [31:0] a, input logic e, input logic [2:0] s,
                        input logic [31:0] v);
    notes.push_back('{1'b0, e, 4'(m), s, v});
    go[m] <= 1'b1;
    goAddr[m] <= a;
  endtask

  task automatic settle();
    int k;
    k = 0;
    @(posedge clk);
    go <= '0;
    do @(negedge clk); while (mstReq !== 11'h0 && ++k < 50);
    @(posedge clk);
  endtask

  task automatic route(input int m, input logic [31:0] a, input logic e, input logic [2:0] s,
                       input logic [31:0] v);
    launch(m, a, e, s, v);
    settle();
  endtask

  task automatic doReset(input logic bs);
    rst_n <= 1'b0;
    bootSelectLevel <= bs;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    logic [31:0] o;
    logic [31:0] hit[3] = '{32'h0030_0000, 32'h0020_0000, 32'h0010_0000};
    logic [31:0] miss[3] = '{32'h0010_0000, 32'h0030_0000, 32'h0010_8000};
    logic [31:0] span[3] = '{32'hffff, 32'hffff, 32'h7fff};
    doReset(1'b1);
    rd(8'h0c, 32'h5);
    bootSelectLevel <= 1'b0;
    rd(8'h0c, 32'h5);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h5c, {16'h0, brmd_pkg::ARB_CFG_RST});
    rd(8'h80, 32'h0);
    $display("register defaults done");
    o = rnd(32'hfffff);
    route(0, o, 1'b0, brmd_pkg::SLV_ROM, brmd_pkg::ROM_BASE + o);
    route(2, 32'h0, 1'b0, brmd_pkg::SLV_ROM, brmd_pkg::ROM_BASE);
    route(1, 32'h0, 1'b0, brmd_pkg::SLV_ROM, brmd_pkg::ROM_BASE);
    o = rnd(32'hffff);
    route(3, brmd_pkg::ROM_BASE + o, 1'b0, brmd_pkg::SLV_ROM, brmd_pkg::ROM_BASE + o);
    route(4, brmd_pkg::SRAM_C_BASE + o, 1'b0, brmd_pkg::SLV_SRAM, brmd_pkg::SRAM_C_BASE + o);
    wr(8'h00, 32'h1);
    rd(8'h0c, 32'h7);
    route(0, o, 1'b0, brmd_pkg::SLV_SRAM, brmd_pkg::SRAM_C_BASE + o);
    route(1, o, 1'b0, brmd_pkg::SLV_SRAM, brmd_pkg::SRAM_C_BASE + o);
    route(2, o, 1'b0, brmd_pkg::SLV_ROM, brmd_pkg::ROM_BASE + o);
    route(5, brmd_pkg::ROM_BASE + o, 1'b0, brmd_pkg::SLV_ROM, brmd_pkg::ROM_BASE + o);
    $display("boot and remap done");
    for (int l = 0; l < 3; l++) begin
      wr(8'h04, 32'(l));
      o = hit[l] + rnd(span[l]);
      route(6, o, 1'b0, brmd_pkg::SLV_SRAM, o);
      route(6, miss[l], 1'b1, 3'h0, 32'h0);
    end
    wr(8'h04, 32'h3);
    rd(8'h04, 32'h2);
    $display("sram layouts done");
    o = 32'h7000_0000 | rnd(32'hffffff);
    route(0, o, 1'b0, brmd_pkg::SLV_DDR0, o);
    route(1, o, 1'b0, brmd_pkg::SLV_DDR1, o);
    route(4, o, 1'b0, brmd_pkg::SLV_DDR2, o);
    route(9, o, 1'b0, brmd_pkg::SLV_DDR3, o);
    wr(8'h08, 32'h1);
    route(7, o, 1'b0, brmd_pkg::SLV_DDR1, o);
    route(0, o, 1'b0, brmd_pkg::SLV_DDR2, o);
    wr(8'h08, 32'h0);
    $display("ddr ports done");
    wr(8'h50, 32'h0000_0200);
    launch(4, o, 1'b0, brmd_pkg::SLV_DDR2, o);
    launch(6, o, 1'b0, brmd_pkg::SLV_DDR2, o);
    notes.push_back('{1'b0, 1'b0, 4'h4, brmd_pkg::SLV_DDR2, o});
    @(posedge clk);
    go[6] <= 1'b0;
    repeat (6) @(posedge clk);
    settle();
    wr(8'h50, 32'h0000_0002);
    launch(8, o, 1'b0, brmd_pkg::SLV_DDR2, o);
    route(4, o, 1'b0, brmd_pkg::SLV_DDR2, o);
    wr(8'h50, 32'h0000_0053);
    @(negedge clk);
    check(40'(slvOwner[4]), 40'h5);
    @(posedge clk);
    wr(8'h50, 32'h0000_00f3);
    rd(8'h50, 32'h0000_0053);
    rd(8'h4c, {16'h0, brmd_pkg::ARB_CFG_RST});
    $display("arbiters done");
    launch(1, o, 1'b0, brmd_pkg::SLV_DDR1, o);
    launch(2, 32'hfff8_0000, 1'b0, brmd_pkg::SLV_PERIPH, 32'hfff8_0000);
    settle();
    route(8, 32'hfff8_0000, 1'b1, 3'h0, 32'h0);
    route(8, brmd_pkg::EBI_CS0_BASE, 1'b0, brmd_pkg::SLV_EBI, brmd_pkg::EBI_CS0_BASE);
    route(3, 32'h8000_0000, 1'b1, 3'h0, 32'h0);
    $display("paths and errors done");
    doReset(1'b0);
    rd(8'h0c, 32'h4);
    o = rnd(32'hfffff);
    route(0, o, 1'b0, brmd_pkg::SLV_EBI, brmd_pkg::EBI_CS0_BASE + o);
    route(5, brmd_pkg::ROM_BASE, 1'b0, brmd_pkg::SLV_ROM, brmd_pkg::ROM_BASE);
    $display("external boot done");
    check(40'(notes.size()), 40'h0);
    results();
  end
endmodule
`default_nettype wire
